/* File: shm_hub_master.sv */
// Purpose: auxiliary I2C master of the sensor hub with host pass-through
// Assumes: configuration arrives as plain ports, trigger is on sys_clk
// Notes: one target only; bit engine runs in four quarter phases per bit
// Behaviour
// RL1: pass-through joins host lines to auxiliary lines
// RL2: host uses pass-through only over I2C
// RL3: host stops master, waits 300 us first
// RL4: host turns auxiliary pull-ups off first
// RL5: host sets pass-through bit last
// RL6: hub configuration accepted only in bank 40h
// RL7: address holds 7-bit target, bit0 selects read
// RL8: setup holds read count up to six, rate
// RL9: host starts with control byte 4Ch
// RL10: host stops with 08h, waits 300 us
// RL11: trigger runs transaction, read completion sets done
// RL12: host clears and polls ready, then done
// RL13: one-shot read byte lands in first result
// RL14: single write sent once, then done flag
// RL15: continuous reads refresh results every trigger
// RL16: host runs accelerometer before hub operations
// RL17: rate field divides trigger by 1,2,4,8
// RL18: read bytes stored in order from first result
// RL19: read uses pointer write, repeated start, acks
`timescale 1ns/1ps
`default_nettype none
module shm_hub_master (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] bankSelect,
	input wire logic cfgWrite,
	input wire shm_pkg::shm_cfg_s cfgIn,
	input wire logic accelSampleReady,
	input wire logic flagsRead,
	input wire logic resultFreeze,
	input wire logic [shm_pkg::RESULT_AW-1:0] resultIndex,
	output logic [7:0] resultData,
	output logic hubCycleDone,
	output logic writeOnceDone,
	output logic busy,
	output logic auxPullupOn,
	input wire logic hostSdaIn,
	output logic hostSdaOut,
	output logic hostSdaOe,
	input wire logic hostSclIn,
	input wire logic auxSdaIn,
	output logic auxSdaOut,
	output logic auxSdaOe,
	input wire logic auxSclIn,
	output logic auxSclOut,
	output logic auxSclOe
);
	// pin synchronisers: host sda, host scl, aux sda, aux scl
	logic [3:0] pinRaw, pinMeta, pinSync;
	assign pinRaw = {hostSdaIn, hostSclIn, auxSdaIn, auxSclIn};
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					pinMeta[g] <= 1'b1;
					pinSync[g] <= 1'b1;
				end else begin
					pinMeta[g] <= pinRaw[g];
					pinSync[g] <= pinMeta[g];
				end
			end
		end
	endgenerate
	logic hostSda, hostScl, auxSda, auxScl;
	assign {hostSda, hostScl, auxSda, auxScl} = pinSync;

	// configuration
	shm_pkg::shm_cfg_s cfg, next_cfg;
	logic masterOn, passThrough;
	assign masterOn = cfg.control[shm_pkg::CTRL_MASTER_ON];
	assign passThrough = cfg.control[shm_pkg::CTRL_PASS_THROUGH];

	always_comb begin
		next_cfg = cfg;
		if (cfgWrite && bankSelect == shm_pkg::HUB_BANK) begin // RL6
			next_cfg = cfgIn;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cfg <= shm_pkg::CFG_RESET;
		end else begin
			cfg <= next_cfg;
		end
	end

	// pass-through: whichever side pulls sda low first owns the direction,
	// otherwise each side would see its own echo and latch the line low
	logic fwdToAux, fwdToHost, fwdHold, next_fwdToAux, next_fwdToHost, next_fwdHold;
	always_comb begin
		next_fwdToAux = fwdToAux;
		next_fwdToHost = fwdToHost;
		next_fwdHold = fwdHold && !(hostSda && auxSda);
		if (!passThrough) begin
			next_fwdToAux = 1'b0;
			next_fwdToHost = 1'b0;
			next_fwdHold = 1'b0;
		end else begin
			// our own drive lingers on the far line for a few cycles after release
			if (fwdToAux && hostSda) begin
				next_fwdToAux = 1'b0;
				next_fwdHold = 1'b1;
			end
			if (fwdToHost && auxSda) begin
				next_fwdToHost = 1'b0;
				next_fwdHold = 1'b1;
			end
			if (!fwdToAux && !fwdToHost && !fwdHold && !hostSda) next_fwdToAux = 1'b1; // RL1
			if (!fwdToAux && !fwdToHost && !fwdHold && hostSda && !auxSda) begin
				next_fwdToHost = 1'b1; // RL1
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fwdToAux <= 1'b0;
			fwdToHost <= 1'b0;
			fwdHold <= 1'b0;
		end else begin
			fwdToAux <= next_fwdToAux;
			fwdToHost <= next_fwdToHost;
			fwdHold <= next_fwdHold;
		end
	end

	// bus engine
	shm_pkg::shm_state_e state, next_state;
	logic [1:0] phase, next_phase;
	logic [7:0] quarter, next_quarter;
	logic [3:0] bitCount, next_bitCount;
	logic [1:0] stage, next_stage;
	logic [7:0] txShift, next_txShift;
	logic [7:0] rxShift, next_rxShift;
	logic [2:0] rdLeft, next_rdLeft;
	logic [shm_pkg::RESULT_AW-1:0] writeIdx, next_writeIdx;
	logic sdaLow, sclLow, next_sdaLow, next_sclLow;
	logic isRead, next_isRead, ackErr, next_ackErr;
	logic wrSpent, next_wrSpent;
	logic [2:0] trigCount, next_trigCount;
	logic next_hubCycleDone, next_writeOnceDone;

	shm_pkg::shm_entry_s pushData;
	logic pushValid, pushReady;
	logic [2:0] numop, rateMask;
	logic fire, quarterDone, step, sclWait;

	assign numop = (cfg.setup[shm_pkg::SETUP_NUMOP_LSB +: 3] > shm_pkg::MAX_READ) ?
		shm_pkg::MAX_READ : cfg.setup[shm_pkg::SETUP_NUMOP_LSB +: 3]; // RL8

	always_comb begin
		case (cfg.setup[shm_pkg::SETUP_RATE_LSB +: 2]) // RL17
			2'h0: rateMask = 3'h0;
			2'h1: rateMask = 3'h1;
			2'h2: rateMask = 3'h3;
			default: rateMask = 3'h7;
		endcase
	end

	assign fire = accelSampleReady && masterOn && !passThrough && ((trigCount & rateMask) == 3'h0);
	assign quarterDone = (quarter == shm_pkg::QUARTER_CYC - 8'h01);
	assign pushValid = (state == shm_pkg::S_RX) && (phase == 2'h3) && (bitCount == 4'h8) &&
		quarterDone;
	// clock held low while the buffer is full: a stalled receiver loses nothing
	assign step = quarterDone && !(pushValid && !pushReady);
	// high time counts only once the line reads high, so a target may stretch it
	assign sclWait = (phase == 2'h1) && !sclLow && !auxScl;
	assign pushData.index = writeIdx;
	assign pushData.data = rxShift;

	always_comb begin
		next_state = state;
		next_phase = phase;
		next_quarter = (state == shm_pkg::S_IDLE || step || sclWait) ? 8'h00 : quarter + 8'h01;
		next_bitCount = bitCount;
		next_stage = stage;
		next_txShift = txShift;
		next_rxShift = rxShift;
		next_rdLeft = rdLeft;
		next_writeIdx = writeIdx;
		next_sdaLow = sdaLow;
		next_sclLow = sclLow;
		next_isRead = isRead;
		next_ackErr = ackErr;
		next_wrSpent = masterOn ? wrSpent : 1'b0;
		next_trigCount = (accelSampleReady && masterOn) ? trigCount + 3'h1 : trigCount;
		next_hubCycleDone = flagsRead ? 1'b0 : hubCycleDone;
		next_writeOnceDone = flagsRead ? 1'b0 : writeOnceDone;
		if (!masterOn) next_trigCount = shm_pkg::TRIG_RESET;
		if (step) next_phase = phase + 2'h1;
		case (state)
			shm_pkg::S_IDLE: begin
				next_phase = 2'h0;
				next_sdaLow = 1'b0;
				next_sclLow = 1'b0;
				if (fire && auxSda && auxScl) begin // RL11
					if (cfg.address[shm_pkg::ADDR_RW_BIT] && numop != 3'h0) begin // RL7
						next_state = shm_pkg::S_START;
						next_isRead = 1'b1;
						next_rdLeft = numop;
						next_writeIdx = '0; // RL18
					end else if (!cfg.address[shm_pkg::ADDR_RW_BIT] && !wrSpent &&
						cfg.control[shm_pkg::CTRL_WRITE_ONCE]) begin // RL14
						next_state = shm_pkg::S_START;
						next_isRead = 1'b0;
					end
					next_ackErr = 1'b0;
				end
			end
			shm_pkg::S_START: begin
				if (step) begin
					case (phase)
						2'h0: next_sdaLow = 1'b1;
						2'h1: next_sclLow = 1'b1;
						2'h2: ;
						default: begin
							next_state = shm_pkg::S_TX;
							next_stage = 2'h0;
							next_bitCount = 4'h0;
							next_txShift = {cfg.address[7:1], 1'b0}; // RL19
						end
					endcase
				end
			end
			shm_pkg::S_TX: begin
				if (step) begin
					case (phase)
						2'h0: next_sclLow = 1'b0;
						2'h1: if (bitCount == 4'h8) next_ackErr = auxSda;
						2'h2: next_sclLow = 1'b1;
						default: begin
							next_bitCount = bitCount + 4'h1;
							next_txShift = {txShift[6:0], 1'b0};
							if (bitCount == 4'h8) begin
								next_bitCount = 4'h0;
								next_stage = stage + 2'h1;
								if (ackErr) begin
									next_state = shm_pkg::S_STOP;
								end else if (stage == 2'h0) begin
									next_txShift = cfg.pointer;
								end else if (stage == 2'h1 && isRead) begin
									next_state = shm_pkg::S_RSTART; // RL19
								end else if (stage == 2'h1) begin
									next_txShift = cfg.writeValue; // RL14
								end else if (isRead) begin
									next_state = shm_pkg::S_RX;
								end else begin
									next_state = shm_pkg::S_STOP;
								end
							end
						end
					endcase
				end
				if (phase == 2'h0) next_sdaLow = (bitCount == 4'h8) ? 1'b0 : !txShift[7];
			end
			shm_pkg::S_RSTART: begin
				if (phase == 2'h0) next_sdaLow = 1'b0;
				if (step) begin
					case (phase)
						2'h0: next_sclLow = 1'b0;
						2'h1: next_sdaLow = 1'b1;
						2'h2: next_sclLow = 1'b1;
						default: begin
							next_state = shm_pkg::S_TX;
							next_bitCount = 4'h0;
							next_txShift = {cfg.address[7:1], 1'b1};
						end
					endcase
				end
			end
			shm_pkg::S_RX: begin
				// ack all bytes but the last
				if (phase == 2'h0) next_sdaLow = (bitCount == 4'h8) && (rdLeft != 3'h1); // RL19
				if (step) begin
					case (phase)
						2'h0: next_sclLow = 1'b0;
						2'h1: if (bitCount != 4'h8) next_rxShift = {rxShift[6:0], auxSda};
						2'h2: next_sclLow = 1'b1;
						default: begin
							next_bitCount = bitCount + 4'h1;
							if (bitCount == 4'h8) begin
								next_bitCount = 4'h0;
								next_writeIdx = writeIdx + shm_pkg::RESULT_AW'(1); // RL18
								next_rdLeft = rdLeft - 3'h1;
								if (rdLeft == 3'h1) next_state = shm_pkg::S_STOP;
							end
						end
					endcase
				end
			end
			shm_pkg::S_STOP: begin
				if (phase == 2'h0) next_sdaLow = 1'b1;
				if (step) begin
					case (phase)
						2'h0: next_sclLow = 1'b0;
						2'h1: next_sdaLow = 1'b0;
						2'h2: ;
						default: begin
							next_state = shm_pkg::S_IDLE;
							if (!ackErr && isRead) next_hubCycleDone = 1'b1; // RL11
							if (!ackErr && !isRead) next_writeOnceDone = 1'b1; // RL14
							if (!isRead) next_wrSpent = 1'b1; // RL14
						end
					endcase
				end
			end
			default: next_state = shm_pkg::S_IDLE;
		endcase
		// master off or pass-through: abandon the transfer and free the lines
		if (!masterOn || passThrough) begin
			next_state = shm_pkg::S_IDLE;
			next_sdaLow = 1'b0;
			next_sclLow = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= shm_pkg::S_IDLE;
			phase <= 2'h0;
			quarter <= 8'h00;
			bitCount <= 4'h0;
			stage <= 2'h0;
			txShift <= 8'h00;
			rxShift <= 8'h00;
			rdLeft <= 3'h0;
			writeIdx <= '0;
			sdaLow <= 1'b0;
			sclLow <= 1'b0;
			isRead <= 1'b0;
			ackErr <= 1'b0;
			wrSpent <= 1'b0;
			trigCount <= shm_pkg::TRIG_RESET;
			hubCycleDone <= 1'b0;
			writeOnceDone <= 1'b0;
		end else begin
			state <= next_state;
			phase <= next_phase;
			quarter <= next_quarter;
			bitCount <= next_bitCount;
			stage <= next_stage;
			txShift <= next_txShift;
			rxShift <= next_rxShift;
			rdLeft <= next_rdLeft;
			writeIdx <= next_writeIdx;
			sdaLow <= next_sdaLow;
			sclLow <= next_sclLow;
			isRead <= next_isRead;
			ackErr <= next_ackErr;
			wrSpent <= next_wrSpent;
			trigCount <= next_trigCount;
			hubCycleDone <= next_hubCycleDone;
			writeOnceDone <= next_writeOnceDone;
		end
	end

	// results: bytes pass the buffer; a host freeze holds storage steady
	shm_pkg::shm_entry_s drainData;
	logic drainValid, drainReady;
	assign drainReady = !resultFreeze;

	shm_pair_buffer u_buffer (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.inValid(pushValid),
		.inReady(pushReady),
		.inData(pushData),
		.outValid(drainValid),
		.outReady(drainReady),
		.outData(drainData)
	);

	shm_result_mem u_results (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.wrEn(drainValid && drainReady), // RL13 RL15
		.wrIndex(drainData.index),
		.wrData(drainData.data),
		.rdIndex(resultIndex),
		.rdData(resultData)
	);

	assign busy = (state != shm_pkg::S_IDLE) || drainValid;
	assign auxPullupOn = cfg.control[shm_pkg::CTRL_PULLUP_ON] && !passThrough;
	assign auxSdaOut = 1'b0;
	assign auxSclOut = 1'b0;
	assign hostSdaOut = 1'b0;
	assign auxSdaOe = passThrough ? fwdToAux : sdaLow; // RL1
	assign auxSclOe = passThrough ? !hostScl : sclLow; // RL1
	assign hostSdaOe = passThrough && fwdToHost; // RL1
endmodule
`default_nettype wire

/* File: shm_pkg.sv */
// Purpose: shared constants and types of the auxiliary sensor hub I2C master
// Assumes: 25 MHz system clock, standard-mode I2C on the auxiliary lines
// Notes: configuration bytes keep the layout the host programs
package shm_pkg;
	// clock and I2C timing
	localparam int CLK_NS = 40;
	localparam int BIT_TIME_NS = 10000;
	// quarter of a bit period, rounded down so the bus never runs slower than planned
	localparam logic [7:0] QUARTER_CYC = 8'((BIT_TIME_NS / 4) / CLK_NS);

	// bank selection
	localparam logic [7:0] HUB_BANK = 8'h40;

	// master control byte fields
	localparam int CTRL_MASTER_ON = 2;
	localparam int CTRL_PULLUP_ON = 3;
	localparam int CTRL_PASS_THROUGH = 4;
	localparam int CTRL_WRITE_ONCE = 6;

	// target0_address fields
	localparam int ADDR_RW_BIT = 0;

	// target0_setup fields
	localparam int SETUP_NUMOP_LSB = 0;
	localparam int SETUP_RATE_LSB = 6;
	localparam logic [2:0] MAX_READ = 3'h6;

	// result storage
	localparam int RESULT_DEPTH = 18;
	localparam int RESULT_AW = 5;

	// reset values
	localparam logic [39:0] CFG_RESET = 40'h00_0000_0000;
	localparam logic [2:0] TRIG_RESET = 3'h0;

	typedef struct packed {
		logic [7:0] address;
		logic [7:0] pointer;
		logic [7:0] setup;
		logic [7:0] writeValue;
		logic [7:0] control;
	} shm_cfg_s;

	typedef struct packed {
		logic [RESULT_AW-1:0] index;
		logic [7:0] data;
	} shm_entry_s;

	typedef enum logic [2:0] {
		S_IDLE,
		S_START,
		S_TX,
		S_RSTART,
		S_RX,
		S_STOP
	} shm_state_e;
endpackage

/* File: shm_pair_buffer.sv */
// Purpose: two-entry buffer between received bytes and result storage
// Assumes: single clock, valid/ready on both sides
// Notes: full when two entries are held; inReady low stalls the bus engine
`timescale 1ns/1ps
`default_nettype none
module shm_pair_buffer (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic inValid,
	output logic inReady,
	input wire shm_pkg::shm_entry_s inData,
	output logic outValid,
	input wire logic outReady,
	output shm_pkg::shm_entry_s outData
);
	shm_pkg::shm_entry_s slot0, slot1, next_slot0, next_slot1;
	logic [1:0] count, next_count;

	assign inReady = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign outData = slot0;

	always_comb begin
		logic doIn;
		logic doOut;
		doIn = inValid && inReady;
		doOut = outValid && outReady;
		next_slot0 = slot0;
		next_slot1 = slot1;
		next_count = count;
		if (doOut) begin
			next_slot0 = slot1;
		end
		if (doIn) begin
			if (count == 2'h0 || (count == 2'h1 && doOut)) begin
				next_slot0 = inData;
			end else begin
				next_slot1 = inData;
			end
		end
		next_count = count + {1'b0, doIn} - {1'b0, doOut};
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			slot0 <= '0;
			slot1 <= '0;
			count <= 2'h0;
		end else begin
			slot0 <= next_slot0;
			slot1 <= next_slot1;
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

/* File: shm_result_mem.sv */
// Purpose: result byte storage with registered read port
// Assumes: one write and one read per cycle
// Notes: out-of-range indices read as zero and are never written
`timescale 1ns/1ps
`default_nettype none
module shm_result_mem (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic wrEn,
	input wire logic [shm_pkg::RESULT_AW-1:0] wrIndex,
	input wire logic [7:0] wrData,
	input wire logic [shm_pkg::RESULT_AW-1:0] rdIndex,
	output logic [7:0] rdData
);
	logic [7:0] mem [shm_pkg::RESULT_DEPTH];
	logic [7:0] next_rdData;

	genvar i;
	generate
		for (i = 0; i < shm_pkg::RESULT_DEPTH; i++) begin : g_entry
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					mem[i] <= 8'h00;
				end else if (wrEn && wrIndex == shm_pkg::RESULT_AW'(i)) begin
					mem[i] <= wrData;
				end
			end
		end
	endgenerate

	always_comb begin
		next_rdData = 8'h00;
		if (rdIndex < shm_pkg::RESULT_AW'(shm_pkg::RESULT_DEPTH)) begin
			next_rdData = mem[rdIndex];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdData <= 8'h00;
		end else begin
			rdData <= next_rdData;
		end
	end
endmodule
`default_nettype wire

/* File: shm_hub_master_monitor.sv */
// Purpose: protocol and flag checks on the auxiliary sensor hub master ports
// Assumes: one clock domain, configuration copied from accepted writes
// Notes: start gap range allows for a few cycles of synchroniser delay
`timescale 1ns/1ps
`default_nettype none
module shm_hub_master_monitor (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] bankSelect,
	input wire logic cfgWrite,
	input wire shm_pkg::shm_cfg_s cfgIn,
	input wire logic flagsRead,
	input wire logic [shm_pkg::RESULT_AW-1:0] resultIndex,
	input wire logic [7:0] resultData,
	input wire logic hubCycleDone,
	input wire logic writeOnceDone,
	input wire logic busy,
	input wire logic auxPullupOn,
	input wire logic hostSclIn,
	input wire logic hostSdaOe,
	input wire logic auxSdaOe,
	input wire logic auxSclOe
);
	logic taken, masterOn, passOn, pullCfg;
	logic next_masterOn, next_passOn, next_pullCfg;
	always_comb begin
		taken = cfgWrite && bankSelect == shm_pkg::HUB_BANK;
		next_masterOn = taken ? cfgIn.control[shm_pkg::CTRL_MASTER_ON] : masterOn;
		next_passOn = taken ? cfgIn.control[shm_pkg::CTRL_PASS_THROUGH] : passOn;
		next_pullCfg = taken ? cfgIn.control[shm_pkg::CTRL_PULLUP_ON] : pullCfg;
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			masterOn <= 1'b0;
			passOn <= 1'b0;
			pullCfg <= 1'b0;
		end else begin
			masterOn <= next_masterOn;
			passOn <= next_passOn;
			pullCfg <= next_pullCfg;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence startEdge;
		$rose(auxSdaOe) && !auxSclOe && masterOn && !passOn;
	endsequence
	sequence sclPulledAfter;
		##[55:70] $rose(auxSclOe);
	endsequence
	chk_pullup_cfg: assert property (auxPullupOn == (pullCfg && !passOn))
		else $error("pull-up enable disagrees with accepted configuration");
	chk_cfg_refused: assert property (!taken |=> $stable(auxPullupOn))
		else $error("configuration changed without an accepted write");
	chk_pass_low: assert property ((passOn && !hostSclIn)[*5] |-> auxSclOe)
		else $error("host clock low not passed to auxiliary clock");
	chk_pass_high: assert property ((passOn && hostSclIn)[*5] |-> !auxSclOe)
		else $error("auxiliary clock held low while host clock high");
	chk_host_quiet: assert property (!passOn[*4] |-> !hostSdaOe)
		else $error("host data driven outside pass-through");
	chk_idle_release: assert property ((!masterOn && !passOn)[*3] |-> !auxSdaOe && !auxSclOe)
		else $error("auxiliary lines driven with master off");
	chk_start_gap: assert property (startEdge |-> sclPulledAfter)
		else $error("start condition not followed by clock low in time");
	chk_flag_clear: assert property (flagsRead && !busy |=> !hubCycleDone && !writeOnceDone)
		else $error("flags not cleared by flag read");
	chk_flag_sticky: assert property (hubCycleDone && !flagsRead |=> hubCycleDone)
		else $error("cycle done flag dropped without flag read");
	chk_done_released: assert property ($rose(hubCycleDone) || $rose(writeOnceDone) |-> !auxSdaOe && !auxSclOe)
		else $error("done flag raised while auxiliary lines driven");
	chk_result_range: assert property (int'(resultIndex) >= shm_pkg::RESULT_DEPTH |=> resultData == 8'h00)
		else $error("result index beyond storage did not read zero");
endmodule
bind shm_hub_master shm_hub_master_monitor chk (.sys_clk, .rstn, .bankSelect, .cfgWrite, .cfgIn,
	.flagsRead, .resultIndex, .resultData, .hubCycleDone, .writeOnceDone, .busy, .auxPullupOn,
	.hostSclIn, .hostSdaOe, .auxSdaOe, .auxSclOe);
`default_nettype wire

/* File: shm_target_model.sv */
// Purpose: behavioural external sensor on the auxiliary bus
// Assumes: both lines pulled up; master changes data only while clock is low
// Notes: nonzero stretchNs holds the clock low after each acknowledge
`timescale 1ns/1ps
`default_nettype none
module shm_target_model #(
	parameter logic [6:0] TARGET_ADDR = 7'h1E
) (
	input wire logic sda,
	input wire logic scl,
	input wire logic [15:0] stretchNs,
	output logic sdaPull,
	output logic sclPull
);
	logic [7:0] mem [0:255];
	logic [7:0] ptr = 8'h00;
	logic [7:0] ptrSeen = 8'h00;
	logic [7:0] rxVal;
	logic ackBit;
	int ev;
	// ev 1 is a start seen mid-byte, 2 a stop
	task automatic rxByte(output logic [7:0] val, output int e);
		logic b;
		val = 8'h00;
		e = 0;
		for (int i = 0; i < 8; i++) begin
			@(posedge scl);
			b = sda;
			wait (scl !== 1'b1 || sda !== b);
			if (scl === 1'b1) begin
				e = b ? 1 : 2;
				return;
			end
			val = {val[6:0], b};
		end
	endtask
	task automatic ackByte();
		sdaPull = 1'b1;
		@(posedge scl);
		@(negedge scl);
		sdaPull = 1'b0;
		if (stretchNs != 16'h0000) begin
			sclPull = 1'b1;
			#(stretchNs);
			sclPull = 1'b0;
		end
	endtask
	task automatic txByte(input logic [7:0] val, output logic nack);
		for (int i = 7; i >= 0; i--) begin
			sdaPull = ~val[i];
			@(posedge scl);
			@(negedge scl);
		end
		sdaPull = 1'b0;
		@(posedge scl);
		nack = sda;
		@(negedge scl);
	endtask
	initial begin
		sdaPull = 1'b0;
		sclPull = 1'b0;
		forever begin
			@(negedge sda iff scl === 1'b1);
			ev = 1;
			while (ev == 1) begin
				rxByte(rxVal, ev);
				if (ev != 0 || rxVal[7:1] !== TARGET_ADDR) break;
				ackByte();
				if (rxVal[0]) begin
					ackBit = 1'b0;
					while (ackBit === 1'b0) begin
						txByte(mem[ptr], ackBit);
						ptr = ptr + 8'h01;
					end
				end else begin
					rxByte(ptr, ev);
					ptrSeen = ptr;
					while (ev == 0) begin
						ackByte();
						rxByte(rxVal, ev);
						if (ev == 0) begin
							mem[ptr] = rxVal;
							ptr = ptr + 8'h01;
						end
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: shm_hub_master_tb.sv */
// Purpose: self-checking bench of the auxiliary sensor hub master
// Assumes: external sensor model answers at a fixed address
// Notes: waits of 7500 cycles stand for the 300 us settle after stopping
`timescale 1ns/1ps
`default_nettype none
module shm_hub_master_tb;
	localparam logic [6:0] TADDR = 7'h1E;
	localparam int LIMIT = 90000;
	localparam int AW = shm_pkg::RESULT_AW;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic cfgWrite = 1'b0;
	logic accelSampleReady = 1'b0;
	logic flagsRead = 1'b0;
	logic resultFreeze = 1'b0;
	logic hostSclIn = 1'b1;
	logic hostSdaLow = 1'b0;
	logic [7:0] bankSelect = 8'h00;
	logic [AW-1:0] resultIndex = '0;
	shm_pkg::shm_cfg_s cfgIn = shm_pkg::CFG_RESET;
	logic [15:0] stretch = 16'h0000;
	logic [31:0] seed = 32'h0001_1E6C;
	logic [7:0] p, v, resultData;
	logic hubCycleDone, writeOnceDone, busy, auxPullupOn, hostSdaOe, auxSdaOe, auxSclOe;
	logic tgtSda, tgtScl;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	wire logic auxSda = ~(auxSdaOe | tgtSda);
	wire logic auxScl = ~(auxSclOe | tgtScl);
	wire logic hostSda = ~(hostSdaOe | hostSdaLow);
	shm_hub_master uut (.sys_clk(sys_clk), .rstn(rstn), .bankSelect(bankSelect),
		.cfgWrite(cfgWrite), .cfgIn(cfgIn), .accelSampleReady(accelSampleReady),
		.flagsRead(flagsRead), .resultFreeze(resultFreeze), .resultIndex(resultIndex),
		.resultData(resultData), .hubCycleDone(hubCycleDone), .writeOnceDone(writeOnceDone),
		.busy(busy), .auxPullupOn(auxPullupOn), .hostSdaIn(hostSda), .hostSdaOut(),
		.hostSdaOe(hostSdaOe), .hostSclIn(hostSclIn), .auxSdaIn(auxSda), .auxSdaOut(),
		.auxSdaOe(auxSdaOe), .auxSclIn(auxScl), .auxSclOut(), .auxSclOe(auxSclOe));
	shm_target_model #(.TARGET_ADDR(TADDR)) tgt (.sda(auxSda), .scl(auxScl),
		.stretchNs(stretch), .sdaPull(tgtSda), .sclPull(tgtScl));
	always #20 sys_clk = ~sys_clk;
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// bank is left deselected after every write, as the host must do
	task automatic cfg(input logic [7:0] bank, a, s, w, c);
		bankSelect = bank;
		cfgWrite = 1'b1;
		cfgIn = {a, p, s, w, c};
		tick(1);
		cfgWrite = 1'b0;
		bankSelect = 8'h00;
	endtask
	task automatic trig();
		accelSampleReady = 1'b1;
		tick(1);
		accelSampleReady = 1'b0;
	endtask
	task automatic clearFlags();
		flagsRead = 1'b1;
		tick(1);
		flagsRead = 1'b0;
	endtask
	task automatic waitDone(input logic rd);
		int i;
		i = 0;
		while ((rd ? hubCycleDone : writeOnceDone) !== 1'b1 && i < 30000) begin
			tick(1);
			i++;
		end
		check("done flag", {7'h00, rd ? hubCycleDone : writeOnceDone}, 8'h01);
	endtask
	task automatic stopHub();
		cfg(shm_pkg::HUB_BANK, cfgIn.address, cfgIn.setup, cfgIn.writeValue, 8'h08);
		tick(7500);
	endtask
	task automatic cmpResults(input int n);
		for (int k = 0; k < n; k++) begin
			resultIndex = AW'(k);
			tick(2);
			check("result byte", resultData, tgt.mem[p + 8'(k)]);
		end
		resultIndex = AW'(shm_pkg::RESULT_DEPTH);
		tick(2);
		check("result beyond end", resultData, 8'h00);
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fail_count++;
			end_sim();
		end
	end
	initial begin
		for (int k = 0; k < 256; k++) begin
			tgt.mem[k] = rnd();
		end
		tick(3);
		rstn = 1'b1;
		check("reset outputs", {5'h00, auxSdaOe, hubCycleDone, writeOnceDone}, 8'h00);
		p = rnd();
		cfg(8'h00, {TADDR, 1'b1}, 8'h01, 8'h00, 8'h4C);
		trig();
		tick(2);
		check("refused config", {6'h00, auxPullupOn, busy}, 8'h00);
		cfg(shm_pkg::HUB_BANK, {TADDR, 1'b1}, 8'h01, 8'h00, 8'h4C);
		check("pull-ups on", {7'h00, auxPullupOn}, 8'h01);
		trig();
		waitDone(1'b1);
		check("pointer sent", tgt.ptrSeen, p);
		stopHub();
		cmpResults(1);
		clearFlags();
		p = rnd();
		stretch = 16'h1F40;
		cfg(shm_pkg::HUB_BANK, {TADDR, 1'b1}, 8'h83, 8'h00, 8'h4C);
		trig();
		waitDone(1'b1);
		cmpResults(3);
		for (int k = 0; k < 3; k++) begin
			tgt.mem[p + 8'(k)] = rnd();
		end
		clearFlags();
		// rate field 10: only every fourth trigger starts a cycle
		for (int k = 0; k < 3; k++) begin
			trig();
			tick(1);
		end
		check("rate skipped", {7'h00, busy}, 8'h00);
		// frozen storage fills the pair buffer, so the third byte must wait
		resultFreeze = 1'b1;
		trig();
		tick(16000);
		check("stalled read", {6'h00, hubCycleDone, busy}, 8'h01);
		resultFreeze = 1'b0;
		waitDone(1'b1);
		tick(4);
		check("drained", {7'h00, busy}, 8'h00);
		cmpResults(3);
		stopHub();
		clearFlags();
		p = rnd();
		v = rnd();
		stretch = 16'h0000;
		cfg(shm_pkg::HUB_BANK, {TADDR, 1'b0}, 8'h00, v, 8'h4C);
		trig();
		waitDone(1'b0);
		check("written byte", tgt.mem[p], v);
		clearFlags();
		trig();
		tick(300);
		check("write once", {6'h00, writeOnceDone, busy}, 8'h00);
		stopHub();
		cfg(shm_pkg::HUB_BANK, {TADDR, 1'b1}, 8'h00, 8'h00, 8'h00);
		tick(1);
		cfg(shm_pkg::HUB_BANK, {TADDR, 1'b1}, 8'h00, 8'h00, 8'h10);
		check("pull-ups off", {7'h00, auxPullupOn}, 8'h00);
		// host clock toggles every 160 ns; data pulled only while clock is low
		for (int k = 0; k < 8; k++) begin
			hostSclIn = ~hostSclIn;
			hostSdaLow = (k == 2);
			tick(4);
			check("pass lines", {5'h00, hostSdaOe, auxSclOe, auxSdaOe},
				{6'h00, ~hostSclIn, hostSdaLow});
		end
		end_sim();
	end
endmodule
`default_nettype wire
